// file: hid_descriptor.sv
// interrupt transfer descriptor store with apb access and polling engine
`default_nettype none
module hid_descriptor #(
  parameter int UFRAME_CYCLES = hid_pkg::UFRAME_CYCLES
) (
  input  wire logic             pclk,      // system clock
  input  wire logic             presetn,   // async reset, low
  input  wire logic             psel,      // apb select
  input  wire logic             penable,   // apb access phase
  input  wire logic             pwrite,    // apb direction
  input  wire logic [7:0]       paddr,     // apb byte address
  input  wire logic [31:0]      pwdata,    // apb write data
  output logic      [31:0]      prdata,    // apb read data
  output logic                  pready,    // apb ready
  output logic                  pslverr,   // apb error, unmapped
  output logic                  irq,       // level interrupt
  output hid_pkg::hid_req_t     req,       // packet request fields
  output logic                  req_start, // pulse: start one packet
  input  wire hid_pkg::hid_rsp_t rsp       // packet answer
);
  import hid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // poll test for slow rates: period mask is the interval value smeared down
  function automatic logic frame_hit(input logic [4:0] ival,
                                     input logic [4:0] fr);
    logic [4:0] m;
    m = ival | (ival >> 1) | (ival >> 2) | (ival >> 3) | (ival >> 4);
    return (fr & m) == ival;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage and timer

  logic [31:0]      dw0_r;
  logic [31:0]      dw1_r;
  logic [31:0]      dw2_r;
  logic [31:0]      dw3_r;
  logic [31:0]      dw4_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mk_r;
  hid_state_t       state_r;
  hid_state_t       state_nxt;
  logic [1:0]       pkt_cnt_r;
  logic             tick;
  logic [2:0]       uframe;
  logic [4:0]       frame;

  // free running: its tick is the only microframe strobe
  hid_uframe_timer #(
    .UFRAME_CYCLES (UFRAME_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .uframe  (uframe),
    .frame   (frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  // descriptor field decode

  wire        valid    = dw0_r[DW0_VALID];
  wire [14:0] to_xfer  = dw0_r[DW0_XFER_LO +: 15];
  wire [10:0] max_len  = dw0_r[DW0_MAXP_LO +: 11];
  wire [1:0]  mult     = dw0_r[DW0_MULT_LO +: 2];
  wire [3:0]  endpoint = {dw1_r[DW1_EP_LO +: 3], dw0_r[DW0_EP_LSB]};   // R14
  wire [6:0]  func     = dw1_r[DW1_FUNC_LO +: 7];                       // R13
  wire [1:0]  token    = dw1_r[DW1_TOKEN_LO +: 2];                      // R12
  wire        split    = dw1_r[DW1_SPLIT];                              // R11
  wire [7:0]  ival     = dw2_r[DW2_IVAL_LO +: 8];
  wire [15:0] ptr      = dw2_r[DW2_PTR_LO +: 16];                       // R7
  wire [14:0] moved    = dw3_r[DW3_MOVED_LO +: 15];
  wire [1:0]  cerr     = dw3_r[DW3_CERR_LO +: 2];
  wire        toggle   = dw3_r[DW3_TOGGLE];
  wire        halted   = dw3_r[DW3_HALT];
  wire        active   = dw3_r[DW3_ACTIVE];
  wire [7:0]  uf_mask  = dw4_r[DW4_MASK_LO +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // poll decision

  // upper interval bits zero means sub-millisecond or 1 ms rate
  wire slow_rate = |ival[7:3];                                          // R9
  wire uf_ok     = uf_mask[uframe];                                     // R10
  wire fr_ok     = slow_rate ? frame_hit(ival[7:3], frame) : 1'b1;      // R8
  // a halted descriptor stays quiet even while valid is set
  wire run_ok    = valid & active & ~halted;                            // R1
  wire poll_go   = tick & run_ok & uf_ok & fr_ok & (state_r == HID_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // answer evaluation

  wire        rsp_here  = rsp.done & (state_r == HID_WAIT);
  wire        is_ack    = rsp_here & (rsp.code == RSP_ACK);
  wire        is_stall  = rsp_here & (rsp.code == RSP_STALL);
  wire        is_err    = rsp_here & (rsp.code == RSP_ERR);
  wire [14:0] new_moved = moved + {4'h0, rsp.bytes};
  // a short packet closes the transfer whatever remains
  wire        short_pkt = rsp.bytes < max_len;
  wire        finished  = is_ack & ((new_moved >= to_xfer) | short_pkt);
  // a zero counter means retries are not limited
  wire        err_fatal = is_err & (cerr == 2'b01);
  wire        fatal     = is_stall | err_fatal;
  // more packets in this poll only after a full-size ack
  wire        more_pkt  = is_ack & ~finished & ({1'b0, pkt_cnt_r} + 2'b01 < {1'b0, mult});
  wire        hw_upd    = rsp_here;

  ////////////////////////////////////////////////////////////////////////////
  // engine state

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HID_IDLE:  if (poll_go) state_nxt = HID_ISSUE;
      HID_ISSUE: state_nxt = HID_WAIT;
      HID_WAIT:  if (rsp_here) state_nxt = more_pkt ? HID_ISSUE : HID_IDLE;
      default:   state_nxt = HID_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= HID_IDLE;
      pkt_cnt_r <= 2'b00;
      req_start <= 1'b0;
      req       <= '0;
    end else begin
      state_r   <= state_nxt;
      req_start <= (state_r == HID_ISSUE);
      if (poll_go) begin
        pkt_cnt_r <= 2'b00;
      end else if (more_pkt) begin
        pkt_cnt_r <= pkt_cnt_r + 2'b01;
      end
      // loaded only here, so fields stand while the function answers
      if (state_r == HID_ISSUE) begin
        req.split       <= split;                                       // R11
        req.token       <= token;                                       // R12
        req.func        <= func;                                        // R13
        req.endpoint    <= endpoint;                                    // R14
        req.toggle      <= toggle;                                      // R3
        req.payload_ptr <= ptr;
        req.byte_offset <= moved;
        req.max_len     <= max_len;
        req.remaining   <= to_xfer - moved;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr     = access & pwrite;
  // full byte compare: an unaligned address is unmapped
  wire hit_d0 = (paddr == OFS_DW0);
  wire hit_d1 = (paddr == OFS_DW1);
  wire hit_d2 = (paddr == OFS_DW2);
  wire hit_d3 = (paddr == OFS_DW3);
  wire hit_d4 = (paddr == OFS_DW4);
  wire hit_st = (paddr == OFS_IRQ_ST);
  wire hit_mk = (paddr == OFS_IRQ_MK);
  wire hit_tm = (paddr == OFS_TIMER);
  wire mapped = hit_d0 | hit_d1 | hit_d2 | hit_d3 | hit_d4 | hit_st | hit_mk | hit_tm;

  // write strobes, live only in the completing access cycle
  wire wr_d0  = wr & hit_d0;
  wire wr_d1  = wr & hit_d1;
  wire wr_d2  = wr & hit_d2;
  wire wr_d3  = wr & hit_d3;
  wire wr_d4  = wr & hit_d4;
  wire wr_st  = wr & hit_st;
  wire wr_mk  = wr & hit_mk;

  // unmapped reads give zero beside the error flag
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_d0) begin
      rd_mux = dw0_r;
    end else if (hit_d1) begin
      rd_mux = dw1_r;
    end else if (hit_d2) begin
      rd_mux = dw2_r;
    end else if (hit_d3) begin
      rd_mux = dw3_r;
    end else if (hit_d4) begin
      rd_mux = dw4_r;
    end else if (hit_st) begin
      rd_mux = {29'h0, irq_st_r};
    end else if (hit_mk) begin
      rd_mux = {29'h0, irq_mk_r};
    end else if (hit_tm) begin
      rd_mux = {24'h0, frame, uframe};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // answer is prepared in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // descriptor words: engine write-back beats a software write in the same cycle

  // reserved bits stay zero: merge never sets them
  logic [31:0] dw0_nxt;
  logic [31:0] dw3_nxt;

  always_comb begin
    dw0_nxt = wr_d0 ? merge(dw0_r, pwdata, DW0_WMASK) : dw0_r;          // R15
    if (finished | fatal) begin
      dw0_nxt[DW0_VALID] = 1'b0;                                        // R15
    end
  end

  always_comb begin
    dw3_nxt = wr_d3 ? merge(dw3_r, pwdata, DW3_WMASK) : dw3_r;          // R4
    if (hw_upd) begin
      if (is_ack) begin
        dw3_nxt[DW3_MOVED_LO +: 15] = new_moved;                        // R5 R6
        dw3_nxt[DW3_TOGGLE]         = ~toggle;                          // R3
      end
      // a zero counter never counts down: retries unlimited
      if (is_err & (cerr != 2'b00)) begin
        dw3_nxt[DW3_CERR_LO +: 2] = cerr - 2'b01;                       // R4
      end
      if (fatal) begin
        dw3_nxt[DW3_HALT] = 1'b1;                                       // R2
      end
      if (finished | fatal) begin
        dw3_nxt[DW3_ACTIVE] = 1'b0;                                     // R1
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dw0_r <= DW_RESET;
      dw1_r <= DW_RESET;
      dw2_r <= DW_RESET;
      dw3_r <= DW_RESET;
      dw4_r <= DW_RESET;
    end else begin
      dw0_r <= dw0_nxt;
      dw3_r <= dw3_nxt;
      if (wr_d1) begin
        dw1_r <= merge(dw1_r, pwdata, DW1_WMASK);
      end
      if (wr_d2) begin
        dw2_r <= merge(dw2_r, pwdata, DW2_WMASK);
      end
      if (wr_d4) begin
        dw4_r <= merge(dw4_r, pwdata, DW4_WMASK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, a new event wins over the clear

  // one event line per status bit, mask has the same layout
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_DONE] = finished;
  assign ev[IRQ_HALT] = fatal;
  assign ev[IRQ_POLL] = poll_go;

  wire [IRQ_W-1:0] clr = wr_st ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] st_nxt = (irq_st_r & ~clr) | ev;
  // a mask written now already gates the level output
  wire [IRQ_W-1:0] mk_nxt = wr_mk ? pwdata[IRQ_W-1:0] : irq_mk_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= {IRQ_W{1'b0}};
      irq_mk_r <= {IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else begin
      irq_st_r <= st_nxt;
      irq_mk_r <= mk_nxt;
      irq      <= |(st_nxt & mk_nxt);
    end
  end

endmodule // hid_descriptor
`default_nettype wire

// file: hid_pkg.sv
// shared constants and types for the interrupt transfer descriptor engine
// Summary of operation
// R1: software loads run-mirror bit equal to valid; engine also updates it.
// R2: engine sets halt flag when the interrupt transaction is halted.
// R3: software seeds toggle_bit; engine writes next toggle after each transaction. The engine here flips it only on an ack.
// R4: two-bit retry counter read/written by software and engine; zero for isochronous.
// R5: engine writes 15-bit moved_byte_count with bytes actually sent or received.
// R6: with multiplier above one, partial counts are stored between packets.
// R7: software gives payload_start_pointer as (cpu address - 400h) / 8.
// R8: poll every 2^(b-1) microframes, interval code b from 1 to 9.
// R9: codes 1..4 clear upper five interval bits; rate set by microframe_select_mask.
// R10: sub-millisecond polling checks the current bit of microframe_select_mask.
// R11: route bit 0 runs native high-speed, 1 runs a split transaction.
// R12: token field selects PID: 00 sends OUT, 01 sends IN.
// R13: transaction goes to the 7-bit function_number.
// R14: endpoint_number built from three upper bits plus lowest bit in lower word.
// R15: software sets valid when payload waits; engine clears it when done or fatal.
// R16: multiplier normally 01b, may be 10b or 11b; 00b is undefined.
`default_nettype none
package hid_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int UFRAME_NS     = 125000;
  localparam int UFRAME_CYCLES = UFRAME_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // apb byte offsets
  localparam logic [7:0] OFS_DW0    = 8'h00;
  localparam logic [7:0] OFS_DW1    = 8'h04;
  localparam logic [7:0] OFS_DW2    = 8'h08;
  localparam logic [7:0] OFS_DW3    = 8'h0c;
  localparam logic [7:0] OFS_DW4    = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h20;
  localparam logic [7:0] OFS_IRQ_MK = 8'h24;
  localparam logic [7:0] OFS_TIMER  = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // descriptor field positions
  localparam int DW0_VALID     = 0;
  localparam int DW0_XFER_LO   = 3;
  localparam int DW0_MAXP_LO   = 18;
  localparam int DW0_MULT_LO   = 29;
  localparam int DW0_EP_LSB    = 31;
  localparam int DW1_EP_LO     = 0;
  localparam int DW1_FUNC_LO   = 3;
  localparam int DW1_TOKEN_LO  = 10;
  localparam int DW1_KIND_LO   = 12;
  localparam int DW1_SPLIT     = 14;
  localparam int DW2_IVAL_LO   = 0;
  localparam int DW2_PTR_LO    = 8;
  localparam int DW3_MOVED_LO  = 0;
  localparam int DW3_CERR_LO   = 23;
  localparam int DW3_TOGGLE    = 25;
  localparam int DW3_HALT      = 30;
  localparam int DW3_ACTIVE    = 31;
  localparam int DW4_MASK_LO   = 0;

  // writable bits of each word; reserved bits read zero
  localparam logic [31:0] DW0_WMASK = 32'hffff_fff9;
  localparam logic [31:0] DW1_WMASK = 32'h0000_7fff;
  localparam logic [31:0] DW2_WMASK = 32'h00ff_ffff;
  localparam logic [31:0] DW3_WMASK = 32'hc380_7fff;
  localparam logic [31:0] DW4_WMASK = 32'h0000_00ff;
  localparam logic [31:0] DW_RESET  = 32'h0000_0000;

  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_POLL = 2;
  localparam int IRQ_W    = 3;

  // token codes and answer codes
  localparam logic [1:0] TOKEN_OUT = 2'b00;
  localparam logic [1:0] TOKEN_IN  = 2'b01;
  localparam logic [1:0] RSP_ACK   = 2'b00;
  localparam logic [1:0] RSP_NAK   = 2'b01;
  localparam logic [1:0] RSP_STALL = 2'b10;
  localparam logic [1:0] RSP_ERR   = 2'b11;

  typedef enum logic [1:0] {
    HID_IDLE  = 2'b00,
    HID_ISSUE = 2'b01,
    HID_WAIT  = 2'b10
  } hid_state_t;

  // request handed to the bus engine
  typedef struct packed {
    logic        split;       // 0 native high-speed, 1 split
    logic [1:0]  token;       // pid select
    logic [6:0]  func;        // function_number
    logic [3:0]  endpoint;    // endpoint_number
    logic        toggle;      // toggle_bit for this packet
    logic [15:0] payload_ptr; // payload_start_pointer
    logic [14:0] byte_offset; // bytes already moved
    logic [10:0] max_len;     // largest packet
    logic [14:0] remaining;   // bytes still to move
  } hid_req_t;

  // answer from the bus engine
  typedef struct packed {
    logic        done;  // one-cycle pulse
    logic [1:0]  code;  // ack, nak, stall, error
    logic [10:0] bytes; // bytes moved by this packet
  } hid_rsp_t;

endpackage
`default_nettype wire

// file: hid_uframe_timer.sv
// microframe and frame counter driven by a cycle divider
`default_nettype none
module hid_uframe_timer #(
  parameter int UFRAME_CYCLES = 6250
) (
  input  wire logic       pclk,     // system clock
  input  wire logic       presetn,  // async reset, low
  output logic            tick,     // pulse at each microframe start
  output logic [2:0]      uframe,   // microframe within frame
  output logic [4:0]      frame     // frame count modulo 32
);
  import hid_pkg::*;

  localparam logic [15:0] LAST = 16'(UFRAME_CYCLES - 1);

  logic [15:0] div_r;
  logic        wrap;

  assign wrap = (div_r == LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 16'h0000;
      tick   <= 1'b0;
      uframe <= 3'h0;
      frame  <= 5'h00;
    end else begin
      div_r <= wrap ? 16'h0000 : div_r + 16'h0001;
      tick  <= wrap;
      if (wrap) begin
        uframe <= uframe + 3'h1;
        if (uframe == 3'h7) begin
          frame <= frame + 5'h01;
        end
      end
    end
  end
endmodule // hid_uframe_timer
`default_nettype wire

// file: hid_descriptor_asserts.sv
// port checker for the interrupt descriptor engine
`default_nettype none
module hid_descriptor_asserts #(
  parameter int UFRAME_CYCLES = 6250
) (
  input wire logic              pclk,      // clock
  input wire logic              presetn,   // reset, low
  input wire logic              psel,      // apb select
  input wire logic              penable,   // apb access
  input wire logic              pwrite,    // apb write
  input wire logic [7:0]        paddr,     // apb address
  input wire logic [31:0]       pwdata,    // apb data
  input wire logic              pready,    // apb ready
  input wire logic              pslverr,   // apb error
  input wire hid_pkg::hid_req_t req,       // packet request
  input wire logic              req_start, // packet start
  input wire hid_pkg::hid_rsp_t rsp        // packet answer
);
  timeunit 1ns;
  timeprecision 1ps;
  import hid_pkg::*;
  logic        acc_wr;
  logic        ack_seen;
  logic        wait_r;
  logic        tg_r;
  logic        ep0_r;
  logic [14:0] dw1_r;
  logic [14:0] mv_r;
  assign acc_wr   = psel && penable && pready && pwrite && !pslverr;
  assign ack_seen = rsp.done && wait_r && rsp.code == RSP_ACK;
  //////////////////////////////////////////////////////////////////
  // shadows of software writes; toggle and moved count also advanced by acknowledged packets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 1'b0;
      tg_r   <= 1'b0;
      ep0_r  <= 1'b0;
      dw1_r  <= '0;
      mv_r   <= '0;
    end else begin
      wait_r <= req_start || (wait_r && !rsp.done);
      if (acc_wr && paddr == OFS_DW0) ep0_r <= pwdata[DW0_EP_LSB];
      if (acc_wr && paddr == OFS_DW1) dw1_r <= pwdata[14:0];
      if (acc_wr && paddr == OFS_DW3) begin
        tg_r <= pwdata[DW3_TOGGLE];
        mv_r <= pwdata[14:0];
      end else if (ack_seen) begin
        tg_r <= ~tg_r;
        mv_r <= mv_r + 15'(rsp.bytes);
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  sequence s_halted;
    rsp.done && wait_r && rsp.code == RSP_STALL;
  endsequence
  sequence s_short;
    ack_seen && rsp.bytes < req.max_len;
  endsequence
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_SPLIT: assert property (req_start |-> req.split == dw1_r[DW1_SPLIT])
    else $error("split select wrong");
  AST_TOKEN: assert property (req_start |-> req.token == dw1_r[DW1_TOKEN_LO +: 2])
    else $error("token wrong");
  AST_FUNC: assert property (req_start |-> req.func == dw1_r[DW1_FUNC_LO +: 7])
    else $error("function number wrong");
  AST_ENDPT: assert property (req_start |-> req.endpoint == {dw1_r[2:0], ep0_r})
    else $error("endpoint number wrong");
  AST_TOGGLE: assert property (req_start |-> req.toggle == tg_r)
    else $error("toggle wrong");
  AST_OFFSET: assert property (req_start |-> req.byte_offset == mv_r)
    else $error("byte offset wrong");
  AST_HALT_QUIET: assert property (s_halted |=> !req_start [*8])
    else $error("packet after halt");
  AST_SHORT_END: assert property (s_short |=> !req_start [*8])
    else $error("packet after short ack");
  AST_REQ_HOLD: assert property ($changed(req) |-> req_start)
    else $error("request changed without start");
endmodule // hid_descriptor_asserts

bind hid_descriptor hid_descriptor_asserts #(.UFRAME_CYCLES(UFRAME_CYCLES)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .req(req),
  .req_start(req_start), .rsp(rsp)
);
`default_nettype wire

// file: hid_func_model.sv
// behavioural downstream function endpoint answering packet requests
`default_nettype none
module hid_func_model (
  input  wire logic              pclk,      // clock
  input  wire logic              presetn,   // reset, low
  input  wire hid_pkg::hid_req_t req,       // packet request
  input  wire logic              req_start, // packet start
  input  wire logic [1:0]        code,      // answer to give
  input  wire logic              short_pkt, // ack one byte short
  output var  hid_pkg::hid_rsp_t rsp        // packet answer
);
  timeunit 1ns;
  timeprecision 1ps;
  import hid_pkg::*;
  int          wait_n;
  logic [10:0] full_n;
  assign full_n = (req.remaining < 15'(req.max_len)) ? req.remaining[10:0] : req.max_len;
  // answer lines toggle between answers so stale values never look valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_n <= 0;
      rsp    <= '0;
    end else if (wait_n == 1) begin
      wait_n <= 0;
      rsp    <= {1'b1, code, (code == RSP_ACK) ? full_n - 11'(short_pkt) : 11'h0};
    end else begin
      if (req_start) wait_n <= 1 + $urandom_range(4);
      else if (wait_n > 1) wait_n <= wait_n - 1;
      rsp <= {1'b0, ~rsp.code, ~rsp.bytes};
    end
  end
endmodule // hid_func_model
`default_nettype wire

// file: hid_descriptor_tb.sv
// self-checking bench for the interrupt descriptor engine
`default_nettype none
module hid_descriptor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hid_pkg::*;
  localparam int UF = 20; // short microframe keeps polls cheap
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, dw0_m;
  hid_req_t    req;
  logic        req_start, short_r, tg, act_m, halt_m, split_m;
  hid_rsp_t    rsp;
  logic [1:0]  code_r, tok_m, st_m;
  logic [6:0]  func_m;
  logic [3:0]  ep_m;
  logic [15:0] ptr_m;
  int          n_mismatch, cmp_count, cyc, xfer, mv, cerr_m, t_last;
  hid_descriptor #(.UFRAME_CYCLES(UF)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .req(req), .req_start(req_start), .rsp(rsp));
  hid_func_model u_func (.pclk(pclk), .presetn(presetn), .req(req), .req_start(req_start),
    .code(code_r), .short_pkt(short_r), .rsp(rsp));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // data and error are taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("data at %h", a), q, x);
    chk($sformatf("error at %h", a), e, xe);
  endtask
  task automatic irqc(input logic x);
    @(negedge pclk);
    chk("irq", irq, x);
    @(posedge pclk);
  endtask
  task automatic desc(input logic s, input logic [1:0] tk, input int mult, input int ce,
                      input logic [7:0] mk, input logic [7:0] iv);
    {split_m, tok_m, func_m, ep_m} = {s, tk, 7'($urandom), 4'($urandom)};
    ptr_m = 16'($urandom);
    tg = 1'($urandom);
    xfer   = mult * 8;
    mv     = 0;
    cerr_m = ce;
    {st_m, act_m, halt_m} = 4'b0010;
    dw0_m = {ep_m[0], 2'(mult), 11'd8, 15'(xfer), 3'b001};
    wr(OFS_DW1, {17'h0, s, 2'b11, tk, func_m, ep_m[3:1]});
    wr(OFS_DW2, {8'h0, ptr_m, iv});
    wr(OFS_DW4, {24'h0, mk});
    wr(OFS_DW3, {1'b1, 5'h0, tg, 2'(ce), 23'h0});
    wr(OFS_DW0, dw0_m);
  endtask
  task automatic pkt(input logic [1:0] c, input logic sh);
    hid_req_t e;
    int       n;
    n = 0;
    code_r  <= c;
    short_r <= sh;
    do @(negedge pclk); while (req_start !== 1'b1 && ++n < 6000);
    if (n >= 6000) n_mismatch++;
    t_last = cyc;
    e = '{split: split_m, token: tok_m, func: func_m, endpoint: ep_m, toggle: tg,
          payload_ptr: ptr_m, byte_offset: 15'(mv), max_len: 11'd8,
          remaining: 15'(xfer - mv)};
    chk("request", req, e);
    n = 0;
    do @(negedge pclk); while (rsp.done !== 1'b1 && ++n < 50);
    if (n >= 50) n_mismatch++;
    if (c == RSP_ACK) begin
      mv += int'(rsp.bytes);
      tg = ~tg;
      st_m[0] = (mv >= xfer || rsp.bytes < 11'd8);
    end
    st_m[1] = (c == RSP_STALL || (c == RSP_ERR && cerr_m == 1));
    if (c == RSP_ERR && cerr_m > 0) cerr_m--;
    {act_m, halt_m} = {st_m == 2'b00, st_m[1]};
    @(posedge pclk);
  endtask
  task automatic fin();
    logic [31:0] q;
    logic        e;
    rc(OFS_DW3, {act_m, halt_m, 4'h0, tg, 2'(cerr_m), 8'h0, 15'(mv)}, 1'b0);
    rc(OFS_DW0, {dw0_m[31:1], act_m}, 1'b0);
    apb(1'b0, OFS_IRQ_ST, 32'h0, q, e);
    chk("event status", q[1:0], st_m);
    irqc(1'b0);
    wr(OFS_IRQ_MK, 32'h3);
    irqc(st_m != 2'b00);
    wr(OFS_IRQ_ST, 32'h7);
    irqc(1'b0);
    wr(OFS_IRQ_MK, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [31:0] wm [5];
    int          per [5];
    logic [7:0]  mks [5];
    logic [7:0]  ivs [5];
    int          t0;
    wm  = '{DW0_WMASK, DW1_WMASK, DW2_WMASK, DW3_WMASK, DW4_WMASK};
    per = '{1, 2, 8, 16, 32};
    mks = '{8'hff, 8'h55, 8'h04, 8'h01, 8'h01};
    ivs = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
    {presetn, psel, penable, pwrite, paddr, pwdata, short_r, code_r} = '0;
    {n_mismatch, cmp_count, cyc} = '0;
    void'($urandom(32'h7e52));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rc(8'(4 * i), 32'h0, 1'b0);
    rc(8'h40, 32'h0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      d = $urandom & 32'h7fff_fffe;
      wr(8'(4 * i), d);
      rc(8'(4 * i), d & wm[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      desc(i[1], {1'b0, i[0]}, 1 + i % 3, 0, 8'hff, 8'h00);
      repeat (1 + i % 3) pkt(RSP_ACK, 1'b0);
      fin();
    end
    desc(1'b0, TOKEN_IN, 3, 0, 8'hff, 8'h00);
    pkt(RSP_ACK, 1'b1);
    fin();
    desc(1'b0, TOKEN_IN, 1, 2, 8'hff, 8'h00);
    pkt(RSP_NAK, 1'b0);
    pkt(RSP_ERR, 1'b0);
    pkt(RSP_ACK, 1'b0);
    fin();
    desc(1'b1, TOKEN_OUT, 1, 1, 8'hff, 8'h00);
    pkt(RSP_ERR, 1'b0);
    fin();
    desc(1'b0, TOKEN_OUT, 1, 0, 8'hff, 8'h00);
    pkt(RSP_ERR, 1'b0);
    pkt(RSP_STALL, 1'b0);
    fin();
    for (int i = 0; i < 5; i++) begin
      desc(1'b0, TOKEN_IN, 1, 0, mks[i], ivs[i]);
      pkt(RSP_NAK, 1'b0);
      t0 = t_last;
      pkt(RSP_NAK, 1'b0);
      chk("poll period", t_last - t0, per[i] * UF);
      wr(OFS_DW0, 32'h0);
    end
    stop_test();
  end
endmodule // hid_descriptor_tb
`default_nettype wire
